/* File: rtl/dtmc_counter.sv */
// One 16-bit counter with the four timer modes
`timescale 1ns/1ps
module dtmc_counter
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Control
	input  wire logic [1:0]  mode,
	input  wire logic        split_ok,
	input  wire logic        inc_lo,
	input  wire logic        inc_hi,
	// Preload from software
	input  wire logic        load,
	input  wire logic [15:0] load_value,
	// State
	output logic      [15:0] count,
	output logic             ovf_lo,
	output logic             ovf_hi
);
	logic [15:0] next_count;
	logic        next_ovf_lo;
	logic        next_ovf_hi;

	always_comb
	begin
		next_count  = count;
		next_ovf_lo = 1'b0;
		next_ovf_hi = 1'b0;
		case (mode)
			dtmc_pkg::MODE_13BIT:
			begin
				if (inc_lo)
				begin
					if (count[4:0] == 5'h1F)
					begin
						next_count[4:0]  = 5'h00;
						next_count[15:8] = count[15:8] + 8'h01;
						next_ovf_lo      = (count[15:8] == 8'hFF);
					end
					else
						next_count[4:0] = count[4:0] + 5'h01;
				end
			end
			dtmc_pkg::MODE_16BIT:
			begin
				if (inc_lo)
				begin
					next_count  = count + 16'h0001;
					next_ovf_lo = (count == 16'hFFFF);
				end
			end
			dtmc_pkg::MODE_8BIT_RELOAD:
			begin
				if (inc_lo)
				begin
					if (count[7:0] == 8'hFF)
					begin
						next_count[7:0] = count[15:8];
						next_ovf_lo     = 1'b1;
					end
					else
						next_count[7:0] = count[7:0] + 8'h01;
				end
			end
			dtmc_pkg::MODE_SPLIT:
			begin
				if (split_ok)
				begin
					if (inc_lo)
					begin
						next_count[7:0] = count[7:0] + 8'h01;
						next_ovf_lo     = (count[7:0] == 8'hFF);
					end
					if (inc_hi)
					begin
						next_count[15:8] = count[15:8] + 8'h01;
						next_ovf_hi      = (count[15:8] == 8'hFF);
					end
				end
			end
			default:
				next_count = count;
		endcase
		if (load)
			next_count = load_value;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			count  <= dtmc_pkg::COUNT_RESET;
			ovf_lo <= 1'b0;
			ovf_hi <= 1'b0;
		end
		else
		begin
			count  <= next_count;
			ovf_lo <= next_ovf_lo;
			ovf_hi <= next_ovf_hi;
		end
	end
endmodule

/* File: rtl/dtmc_pkg.sv */
// Constants for the dual timer mode control block
package dtmc_pkg;
	localparam logic [7:0] TIMER_MODE_CONFIG_ADDR  = 8'h89;
	localparam logic [7:0] TIMER_MODE_CONFIG_RESET = 8'h00;
	localparam int         T1_GATE_BIT             = 7;
	localparam int         T1_COUNT_SEL_BIT        = 6;
	localparam int         T1_MODE_LSB             = 4;
	localparam int         T0_GATE_BIT             = 3;
	localparam int         T0_COUNT_SEL_BIT        = 2;
	localparam int         T0_MODE_LSB             = 0;
	localparam logic [1:0] MODE_13BIT              = 2'h0;
	localparam logic [1:0] MODE_16BIT              = 2'h1;
	localparam logic [1:0] MODE_8BIT_RELOAD        = 2'h2;
	localparam logic [1:0] MODE_SPLIT              = 2'h3;
	localparam logic [15:0] COUNT_RESET            = 16'h0000;
endpackage

/* File: rtl/dtmc_top.sv */
// Timer mode register, gating, clock select and two timers
`timescale 1ns/1ps
// What this block does
// - Timer 1 gate bit adds gate pin condition
// - Timer 1 counts prescaled clock or pin falls
// - Timer 1 modes: 13, 16, reload, inactive
// - Timer 0 gate bit adds gate pin condition
// - Timer 0 counts prescaled clock or pin falls
// - Timer 0 modes: 13, 16, reload, split
module dtmc_top
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	// Run bits and external interrupt configuration
	input  wire logic        timer0_run,
	input  wire logic        timer1_run,
	input  wire logic        timer0_gate_ctrl_polarity,
	input  wire logic        timer1_gate_ctrl_polarity,
	// Prescale clock selection and tick
	input  wire logic        timer0_clock_sel,
	input  wire logic        timer1_clock_sel,
	input  wire logic        prescale_tick,
	// External pins
	input  wire logic        ext_gate_input0,
	input  wire logic        ext_gate_input1,
	input  wire logic        ext_count_pin0,
	input  wire logic        ext_count_pin1,
	// Counter preload
	input  wire logic        timer0_load,
	input  wire logic        timer1_load,
	input  wire logic [15:0] load_value,
	// Overflow flag clears
	input  wire logic        timer0_ovf_clear,
	input  wire logic        timer1_ovf_clear,
	// Status
	output logic      [15:0] timer0_count,
	output logic      [15:0] timer1_count,
	output logic             timer0_ovf_flag,
	output logic             timer1_ovf_flag
);
	logic [7:0] timer_mode_config;
	logic       pin0_q;
	logic       pin1_q;
	logic       fall0;
	logic       fall1;
	logic       timer0_gate_ctrl_ok;
	logic       timer1_gate_ctrl_ok;
	logic       en0;
	logic       en1;
	logic       src0;
	logic       src1;
	logic       split;
	logic       ovf0_lo;
	logic       ovf0_hi;
	logic       ovf1;
	logic [1:0] t0_mode;
	logic [1:0] t1_mode;
	logic       t1_inc;
	logic       cfg_hit;
	logic       t0_gate_en;
	logic       t0_pin_sel;
	logic       t1_gate_en;
	logic       t1_pin_sel;
	logic       inc0_lo;
	logic       inc0_hi;

	////////////////////////////////////////////////////////////////
	// Mode register
	// Only the mode register address is decoded
	assign cfg_hit = (reg_addr == dtmc_pkg::TIMER_MODE_CONFIG_ADDR);

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			timer_mode_config <= dtmc_pkg::TIMER_MODE_CONFIG_RESET;
		else if (reg_wr && cfg_hit)
			timer_mode_config <= reg_wdata;
	end

	// Unmapped addresses read as zero
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			reg_rdata <= 8'h00;
		else if (cfg_hit)
			reg_rdata <= timer_mode_config;
		else
			reg_rdata <= 8'h00;
	end

	// Control fields of the mode register
	assign t0_mode    = timer_mode_config[dtmc_pkg::T0_MODE_LSB +: 2];
	assign t1_mode    = timer_mode_config[dtmc_pkg::T1_MODE_LSB +: 2];
	assign t0_gate_en = timer_mode_config[dtmc_pkg::T0_GATE_BIT];
	assign t0_pin_sel = timer_mode_config[dtmc_pkg::T0_COUNT_SEL_BIT];
	assign t1_gate_en = timer_mode_config[dtmc_pkg::T1_GATE_BIT];
	assign t1_pin_sel = timer_mode_config[dtmc_pkg::T1_COUNT_SEL_BIT];
	// Split mode is decided by timer 0 mode field alone
	assign split      = (t0_mode == dtmc_pkg::MODE_SPLIT);

	////////////////////////////////////////////////////////////////
	// Count pin edge detection, pins synchronous to clk
	// Low after reset, so a pin held low through reset gives no fall
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			pin0_q <= 1'b0;
		else
			pin0_q <= ext_count_pin0;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			pin1_q <= 1'b0;
		else
			pin1_q <= ext_count_pin1;
	end

	assign fall0 = pin0_q && !ext_count_pin0;
	assign fall1 = pin1_q && !ext_count_pin1;

	////////////////////////////////////////////////////////////////
	// Timer 0 gating and count source
	always_comb
	begin
		timer0_gate_ctrl_ok = 1'b1;
		src0     = timer0_clock_sel || prescale_tick;
		if (t0_gate_en)
			timer0_gate_ctrl_ok = (ext_gate_input0 == timer0_gate_ctrl_polarity);
		if (t0_pin_sel)
			src0 = fall0;
	end

	assign en0 = timer0_run && timer0_gate_ctrl_ok;

	////////////////////////////////////////////////////////////////
	// Timer 1 gating and count source
	always_comb
	begin
		timer1_gate_ctrl_ok = 1'b1;
		src1     = timer1_clock_sel || prescale_tick;
		if (t1_gate_en)
			timer1_gate_ctrl_ok = (ext_gate_input1 == timer1_gate_ctrl_polarity);
		if (t1_pin_sel)
			src1 = fall1;
	end

	assign en1 = timer1_run && timer1_gate_ctrl_ok;

	////////////////////////////////////////////////////////////////
	// Increment requests
	assign inc0_lo = en0 && src0;
	// Split high byte follows timer 1 run and clock choice, ungated
	assign inc0_hi = split && timer1_run && (timer1_clock_sel || prescale_tick);
	// Mode 3 holds timer 1
	assign t1_inc  = en1 && src1 && (t1_mode != dtmc_pkg::MODE_SPLIT);

	////////////////////////////////////////////////////////////////
	// Counters
	// Timer 0 may split into two 8-bit halves
	dtmc_counter u_timer0
	(
		.clk        (clk),
		.resetn     (resetn),
		.mode       (t0_mode),
		.split_ok   (1'b1),
		.inc_lo     (inc0_lo),
		.inc_hi     (inc0_hi),
		.load       (timer0_load),
		.load_value (load_value),
		.count      (timer0_count),
		.ovf_lo     (ovf0_lo),
		.ovf_hi     (ovf0_hi)
	);

	// Timer 1 has no split; its mode 3 holds the count
	dtmc_counter u_timer1
	(
		.clk        (clk),
		.resetn     (resetn),
		.mode       (t1_mode),
		.split_ok   (1'b0),
		.inc_lo     (t1_inc),
		.inc_hi     (1'b0),
		.load       (timer1_load),
		.load_value (load_value),
		.count      (timer1_count),
		.ovf_lo     (ovf1),
		.ovf_hi     ()
	);

	////////////////////////////////////////////////////////////////
	// Timer 0 overflow flag, set wins over clear
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			timer0_ovf_flag <= 1'b0;
		else if (ovf0_lo)
			timer0_ovf_flag <= 1'b1;
		else if (timer0_ovf_clear)
			timer0_ovf_flag <= 1'b0;
	end

	// Timer 1 overflow flag, also set by the split high byte
	// Set wins over clear so no overflow is lost
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			timer1_ovf_flag <= 1'b0;
		else if (ovf1 || (split && ovf0_hi))
			timer1_ovf_flag <= 1'b1;
		else if (timer1_ovf_clear)
			timer1_ovf_flag <= 1'b0;
	end
endmodule

/* File: verification/dtmc_checker.sv */
// Assertions on the timer mode block ports
`timescale 1ns/1ps
module dtmc_checker
(
	// Watched ports
	input wire logic        clk, resetn, reg_wr, timer0_run, timer1_run, timer0_load, timer1_load,
	input wire logic        timer0_gate_ctrl_polarity, timer1_gate_ctrl_polarity, ext_gate_input0, ext_gate_input1,
	input wire logic        timer0_clock_sel, prescale_tick, ext_count_pin1, timer0_ovf_flag,
	input wire logic [7:0]  reg_addr, reg_wdata,
	input wire logic [15:0] timer0_count, timer1_count
);
	logic [7:0] c;
	logic       t0i;
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
			c <= 8'h00;
		else if (reg_wr && reg_addr == 8'h89)
			c <= reg_wdata;
	// Timer 0 takes a clock count this edge
	assign t0i = timer0_run && (!c[3] || ext_gate_input0 == timer0_gate_ctrl_polarity) && !c[2]
		&& (timer0_clock_sel || prescale_tick) && !timer0_load;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!resetn);
	property p_g1; c[7] && ext_gate_input1 != timer1_gate_ctrl_polarity && !timer1_load |=> $stable(timer1_count); endproperty
	a_g1: assert property (p_g1) else $error("gated timer 1 moved");
	property p_c1; timer1_run && c[7:4] == 4'h5 && c[1:0] != 2'h3 && !timer1_load && $fell(ext_count_pin1)
		|=> timer1_count == $past(timer1_count) + 16'h1; endproperty
	a_c1: assert property (p_c1) else $error("pin fall not counted");
	property p_i1; c[5:4] == 2'h3 && !timer1_load |=> $stable(timer1_count); endproperty
	a_i1: assert property (p_i1) else $error("inactive timer 1 moved");
	property p_g0; c[3] && ext_gate_input0 != timer0_gate_ctrl_polarity && c[1:0] != 2'h3 && !timer0_load
		|=> $stable(timer0_count); endproperty
	a_g0: assert property (p_g0) else $error("gated timer 0 moved");
	property p_c0; t0i && c[1:0] == 2'h1 |=> timer0_count == $past(timer0_count) + 16'h1; endproperty
	a_c0: assert property (p_c0) else $error("clock not counted");
	property p_r0; t0i && c[1:0] == 2'h2 && timer0_count[7:0] == 8'hFF
		|=> timer0_count[7:0] == timer0_count[15:8] && $stable(timer0_count[15:8]); endproperty
	a_r0: assert property (p_r0) else $error("no reload");
	// Counter overflow is registered, the flag follows one edge later
	property p_o0; t0i && c[1:0] == 2'h1 && timer0_count == 16'hFFFF |-> ##2 timer0_ovf_flag; endproperty
	a_o0: assert property (p_o0) else $error("no overflow flag");
endmodule

/* File: verification/dtmc_pins.sv */
// Model of the external gate and count pins
`timescale 1ns/1ps
module dtmc_pins
(
	// Requested gate levels and count pulse
	input  wire logic g0, g1, f,
	// Pin levels
	output logic      ext_gate_input0, ext_gate_input1, ext_count_pin0, ext_count_pin1
);
	assign ext_gate_input0 = g0;
	assign ext_gate_input1 = g1;
	// Count pins idle high, a pulse pulls both low
	assign ext_count_pin0 = !f;
	assign ext_count_pin1 = !f;
endmodule

/* File: verification/dtmc_top_test.sv */
// Self-checking bench for the timer mode block
`timescale 1ns/1ps
module dtmc_top_test;
	logic        clk, resetn, reg_wr, timer0_run, timer1_run, timer0_gate_ctrl_polarity, timer1_gate_ctrl_polarity, efl;
	logic        timer0_clock_sel, timer1_clock_sel, prescale_tick, timer0_load, timer1_load;
	logic        timer0_ovf_clear, timer1_ovf_clear, g0, g1, f, timer0_ovf_flag, timer1_ovf_flag;
	logic        ext_gate_input0, ext_gate_input1, ext_count_pin0, ext_count_pin1;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
	logic [15:0] load_value, timer0_count, timer1_count;
	int          bad_count = 0, check_count = 0, cyc = 0;
	dtmc_pins u_pins (.g0, .g1, .f, .ext_gate_input0, .ext_gate_input1, .ext_count_pin0, .ext_count_pin1);
	dtmc_top u_dut (.clk, .resetn, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .timer0_run, .timer1_run,
		.timer0_gate_ctrl_polarity, .timer1_gate_ctrl_polarity, .timer0_clock_sel, .timer1_clock_sel, .prescale_tick,
		.ext_gate_input0, .ext_gate_input1, .ext_count_pin0, .ext_count_pin1, .timer0_load, .timer1_load,
		.load_value, .timer0_ovf_clear, .timer1_ovf_clear, .timer0_count, .timer1_count, .timer0_ovf_flag,
		.timer1_ovf_flag);
	always #50 clk = !clk;
	task report_and_stop;
		$display("checks %0d, mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 12000)
		begin
			bad_count++;
			report_and_stop;
		end
	end
	task automatic chk(input string nm, input logic [16:0] s, input logic [16:0] e);
		check_count++;
		if (s !== e)
		begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", nm, e, s);
		end
	endtask
	task automatic regrd(input logic [7:0] a, input logic [7:0] e);
		reg_addr = a;
		@(negedge clk);
		chk("reg_rdata", {9'h0, reg_rdata}, {9'h0, e});
	endtask
	task automatic regw(input logic [7:0] v);
		{reg_addr, reg_wdata, reg_wr} = {8'h89, v, 1'b1};
		@(negedge clk);
		reg_wr = 1'b0;
	endtask
	// Expected counter after n counts, flags wraps in efl
	function automatic logic [15:0] adv(input logic [1:0] m, input logic [15:0] c, input int n);
		repeat (n)
		begin
			efl |= m[1] ? c[7:0] == 8'hFF : c == (m[0] ? 16'hFFFF : 16'hFF1F);
			case (m)
				2'h0: c = c[4:0] == 5'h1F ? {c[15:8] + 8'h1, 8'h00} : c + 16'h1;
				2'h2: c = c[7:0] == 8'hFF ? {c[15:8], c[15:8]} : c + 16'h1;
				2'h3: c[7:0] = c[7:0] + 8'h1;
				default: c = c + 16'h1;
			endcase
		end
		return c;
	endfunction
	// Load near the top, count clocks or pin falls, compare count and flag
	task automatic tr(input bit t, input logic [3:0] h, input bit gk);
		logic [15:0] v;
		int          k;
		k = 0;
		v = 16'hFFFF - 16'($urandom_range(40));
		if (h[1:0] == 2'h0)
			v = v & 16'hFF1F;
		regw(t ? {h, 4'h0} : {4'h0, h});
		{timer0_load, timer1_load, timer0_ovf_clear, timer1_ovf_clear, load_value} = {!t, t, 2'h3, v};
		{timer0_gate_ctrl_polarity, timer1_gate_ctrl_polarity} = 2'($urandom);
		g0 = gk ~^ timer0_gate_ctrl_polarity;
		g1 = gk ~^ timer1_gate_ctrl_polarity;
		@(negedge clk);
		{timer0_load, timer1_load, timer0_ovf_clear, timer1_ovf_clear, timer0_run, timer1_run} = {4'h0, !t, t};
		repeat (80)
		begin
			{timer0_clock_sel, timer1_clock_sel, prescale_tick} = 3'($urandom);
			k += int'(h[2] | (t ? timer1_clock_sel : timer0_clock_sel) | prescale_tick);
			f = 1'b1;
			@(negedge clk);
			{timer0_clock_sel, timer1_clock_sel, prescale_tick, f} = 4'h0;
			@(negedge clk);
		end
		{timer0_run, timer1_run} = 2'h0;
		efl = 1'b0;
		v = adv(h[1:0], v, (h[3] && !gk) || (t && h[1:0] == 2'h3) ? 0 : k);
		chk("timer", t ? {timer1_ovf_flag, timer1_count} : {timer0_ovf_flag, timer0_count}, {efl, v});
	endtask
	initial
	begin
		{clk, resetn, reg_wr, timer0_run, timer1_run, timer0_gate_ctrl_polarity, timer1_gate_ctrl_polarity, efl} = 8'h00;
		{timer0_clock_sel, timer1_clock_sel, prescale_tick, timer0_load, timer1_load} = 5'h00;
		{timer0_ovf_clear, timer1_ovf_clear, g0, g1, f} = 5'h00;
		{reg_addr, reg_wdata, load_value} = 32'h0000_0000;
		void'($urandom(69930));
		repeat (10) @(negedge clk);
		resetn = 1'b1;
		regrd(8'h89, 8'h00);
		regrd(8'h8A, 8'h00);
		repeat (4)
		begin
			d = 8'($urandom);
			regw(d);
			regrd(8'h89, d);
		end
		for (int t = 0; t < 2; t++)
			for (int i = 0; i < 16; i++)
				tr(t[0], {i[2], t[0] ^ i[3], i[1:0]}, i[0]);
		// Mid-run reset returns register, count and flag to zero
		resetn = 1'b0;
		@(negedge clk);
		resetn = 1'b1;
		regrd(8'h89, 8'h00);
		chk("timer0 after reset", {timer0_ovf_flag, timer0_count}, 17'h00000);
		report_and_stop;
	end
endmodule
bind dtmc_top dtmc_checker u_chk (.clk, .resetn, .reg_wr, .timer0_run, .timer1_run, .timer0_load, .timer1_load,
	.timer0_gate_ctrl_polarity, .timer1_gate_ctrl_polarity, .ext_gate_input0, .ext_gate_input1, .timer0_clock_sel, .prescale_tick,
	.ext_count_pin1, .timer0_ovf_flag, .reg_addr, .reg_wdata, .timer0_count, .timer1_count);
